// ---- design/pamfe_pkg.sv ----
// Behaviour
// - safety mask B AND word B flags safety
// - safety mask C AND word C flags safety
// - fail mask A AND word A flags fail
// - fail mask B AND word B flags fail
// - fail mask C AND word C flags fail
// - fail mask D bit 0 AND word D bit 0 flags fail
// - fail enable A gates latching, defaults zero
// - fail enable B gates latching, defaults zero
// - fail enable C holds eight enables, default 0x07
// - enable C reads 1 enabled, 0 disabled
// - safety mask A AND word A flags safety
// - safety aggregate bit 12, fail aggregate bit 11
package pamfe_pkg;

   // ****************************************************************
   // bus and word geometry
   // ****************************************************************
   localparam int PAMFE_ADDR_W   = 8;
   localparam int PAMFE_DATA_W   = 32;
   localparam int PAMFE_WORD_W   = 8;
   localparam int PAMFE_N_WORDS  = 7;
   localparam int PAMFE_N_SAFETY = 3;
   localparam int PAMFE_N_ENABLE = 3;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFF_SAFETY_MASK_A = 8'h00;
   localparam logic [7:0] OFF_SAFETY_MASK_B = 8'h04;
   localparam logic [7:0] OFF_SAFETY_MASK_C = 8'h08;
   localparam logic [7:0] OFF_FAIL_MASK_A   = 8'h0C;
   localparam logic [7:0] OFF_FAIL_MASK_B   = 8'h10;
   localparam logic [7:0] OFF_FAIL_MASK_C   = 8'h14;
   localparam logic [7:0] OFF_FAIL_MASK_D   = 8'h18;
   localparam logic [7:0] OFF_FAIL_ENABLE_A = 8'h1C;
   localparam logic [7:0] OFF_FAIL_ENABLE_B = 8'h20;
   localparam logic [7:0] OFF_FAIL_ENABLE_C = 8'h24;
   localparam logic [7:0] OFF_RAW_ALARM     = 8'h28;
   localparam logic [7:0] OFF_IRQ_STATUS    = 8'h2C;
   localparam logic [7:0] OFF_IRQ_MASK      = 8'h30;
   localparam logic [7:0] OFF_HIT_SUMMARY   = 8'h34;

   // ****************************************************************
   // register slots (order of the mask array, then enables)
   // ****************************************************************
   localparam logic [4:0] SLOT_ENABLE_BASE = 5'h07;
   localparam logic [4:0] SLOT_RAW_ALARM   = 5'h0A;
   localparam logic [4:0] SLOT_IRQ_STATUS  = 5'h0B;
   localparam logic [4:0] SLOT_IRQ_MASK    = 5'h0C;
   localparam logic [4:0] SLOT_HIT_SUMMARY = 5'h0D;
   localparam logic [4:0] SLOT_NONE        = 5'h1F;

   // ****************************************************************
   // reset values and implemented bit positions
   // ****************************************************************
   // order: safety A, B, C, fail A, B, C, D
   localparam logic [7:0] MASK_RST [PAMFE_N_WORDS] =
      '{8'hFC, 8'hF7, 8'hF4, 8'h5F, 8'h9F, 8'h00, 8'h00};
   localparam logic [7:0] MASK_VALID [PAMFE_N_WORDS] =
      '{8'hFC, 8'hF7, 8'hF4, 8'hDF, 8'h9F, 8'h78, 8'h01};
   // order: enable A, B, C
   localparam logic [7:0] ENABLE_RST [PAMFE_N_ENABLE] =
      '{8'h00, 8'h00, 8'h07};
   localparam logic [7:0] ENABLE_VALID [PAMFE_N_ENABLE] =
      '{8'hDF, 8'h9F, 8'hFF};

   // ****************************************************************
   // alarm and interrupt fields
   // ****************************************************************
   localparam int RAW_SAFETY_BIT = 12;
   localparam int RAW_FAIL_BIT   = 11;
   localparam int IRQ_SAFETY_BIT = 0;
   localparam int IRQ_FAIL_BIT   = 1;
   localparam int IRQ_W          = 2;
   localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 2'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST   = 2'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pamfe_pkg

// ---- design/pamfe_regbus_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface pamfe_regbus_if #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 32
);
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_ok;
   logic              rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_ok;

   modport bus (
      output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input  wr_ok, rd_data, rd_ok
   );
   modport regs (
      input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_ok, rd_data, rd_ok
   );
endinterface : pamfe_regbus_if
`default_nettype wire

// ---- design/pamfe_axil_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module pamfe_axil_slave
   import pamfe_pkg::*;
#(
   parameter int ADDR_W = PAMFE_ADDR_W,
   parameter int DATA_W = PAMFE_DATA_W
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   pamfe_regbus_if.bus            rb
);

   // ****************************************************************
   // write path: address and data may arrive in either order
   // ****************************************************************
   logic              aw_held_r;
   logic              w_held_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [3:0]        wstrb_r;

   // readies drop once a beat is held, so one write at a time
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

   assign rb.wr_en   = aw_held_r && w_held_r && !s_axi_bvalid;
   assign rb.wr_addr = awaddr_r;
   assign rb.wr_data = wdata_r;
   assign rb.wr_strb = wstrb_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (rb.wr_en) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (rb.wr_en) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (rb.wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // read path: data captured at the address handshake
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;
   assign rb.rd_en      = s_axi_arvalid && s_axi_arready;
   assign rb.rd_addr    = s_axi_araddr;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rb.rd_en) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rb.rd_data;
         s_axi_rresp  <= rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : pamfe_axil_slave
`default_nettype wire

// ---- design/pamfe_alert_eval.sv ----
`timescale 1ns/1ns
`default_nettype none
module pamfe_alert_eval
   import pamfe_pkg::*;
#(
   parameter int N_WORDS  = PAMFE_N_WORDS,
   parameter int N_SAFETY = PAMFE_N_SAFETY,
   parameter int WORD_W   = PAMFE_WORD_W
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [WORD_W-1:0] mask_words  [N_WORDS],
   input  wire logic [WORD_W-1:0] alert_words [N_WORDS],
   output logic                   safety_agg,
   output logic                   fail_agg,
   output logic [N_WORDS-1:0]     hit_words
);

   // ****************************************************************
   // per-word AND reduction
   // ****************************************************************
   logic [N_WORDS-1:0] hit;

   genvar i;
   generate
      for (i = 0; i < N_WORDS; i++) begin : g_word
         // implemented positions only, whatever the stored mask holds
         assign hit[i] = |(mask_words[i] & alert_words[i]
                           & MASK_VALID[i]);
      end
   endgenerate

   // ****************************************************************
   // registered aggregates, refreshed every cycle
   // ****************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         safety_agg <= 1'b0;
         fail_agg   <= 1'b0;
         hit_words  <= '0;
      end else begin
         safety_agg <= |hit[N_SAFETY-1:0];
         fail_agg   <= |hit[N_WORDS-1:N_SAFETY];
         hit_words  <= hit;
      end
   end

endmodule : pamfe_alert_eval
`default_nettype wire

// ---- design/pamfe_top.sv ----
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module pamfe_top
   import pamfe_pkg::*;
#(
   parameter int ADDR_W = PAMFE_ADDR_W
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // register bus
   input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [PAMFE_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [ADDR_W-1:0]       s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [PAMFE_DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // alert words from the detection logic, same clock
   input  wire logic [7:0]              safety_alert_word_a,
   input  wire logic [7:0]              safety_alert_word_b,
   input  wire logic [7:0]              safety_alert_word_c,
   input  wire logic [7:0]              fail_alert_word_a,
   input  wire logic [7:0]              fail_alert_word_b,
   input  wire logic [7:0]              fail_alert_word_c,
   input  wire logic [7:0]              fail_alert_word_d,
   // results
   output logic                         masked_safety_alert_flag,
   output logic                         masked_fail_alert_flag,
   output logic [15:0]                  raw_alarm_flags,
   output logic [7:0]                   perm_fail_enable_a,
   output logic [7:0]                   perm_fail_enable_b,
   output logic [7:0]                   perm_fail_enable_c,
   output logic                         irq
);

   // ****************************************************************
   // address decode
   // ****************************************************************
   function automatic logic [4:0] reg_slot(input logic [ADDR_W-1:0] a);
      logic [7:0] a8;
      a8 = 8'(a);
      unique case (a8)
         OFF_SAFETY_MASK_A: reg_slot = 5'h00;
         OFF_SAFETY_MASK_B: reg_slot = 5'h01;
         OFF_SAFETY_MASK_C: reg_slot = 5'h02;
         OFF_FAIL_MASK_A:   reg_slot = 5'h03;
         OFF_FAIL_MASK_B:   reg_slot = 5'h04;
         OFF_FAIL_MASK_C:   reg_slot = 5'h05;
         OFF_FAIL_MASK_D:   reg_slot = 5'h06;
         OFF_FAIL_ENABLE_A: reg_slot = SLOT_ENABLE_BASE;
         OFF_FAIL_ENABLE_B: reg_slot = 5'(SLOT_ENABLE_BASE + 5'h01);
         OFF_FAIL_ENABLE_C: reg_slot = 5'(SLOT_ENABLE_BASE + 5'h02);
         OFF_RAW_ALARM:     reg_slot = SLOT_RAW_ALARM;
         OFF_IRQ_STATUS:    reg_slot = SLOT_IRQ_STATUS;
         OFF_IRQ_MASK:      reg_slot = SLOT_IRQ_MASK;
         OFF_HIT_SUMMARY:   reg_slot = SLOT_HIT_SUMMARY;
         default:           reg_slot = SLOT_NONE;
      endcase
   endfunction : reg_slot

   // ****************************************************************
   // bus slave
   // ****************************************************************
   pamfe_regbus_if #(.ADDR_W(ADDR_W), .DATA_W(PAMFE_DATA_W)) rb ();

   pamfe_axil_slave #(
      .ADDR_W (ADDR_W),
      .DATA_W (PAMFE_DATA_W)
   ) u_slave (
      .core_clk      (core_clk),
      .rst           (rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .rb            (rb.bus)
   );

   logic [4:0] wr_slot;
   logic       wr_byte;
   logic [7:0] wr_byte_data;

   assign wr_slot      = reg_slot(rb.wr_addr);
   // registers live in byte lane 0; upper lanes are ignored
   assign wr_byte      = rb.wr_en && rb.wr_strb[0];
   assign wr_byte_data = rb.wr_data[7:0];
   assign rb.wr_ok     = (wr_slot != SLOT_NONE);

   // ****************************************************************
   // alert masks
   // ****************************************************************
   logic [7:0] mask_r  [PAMFE_N_WORDS];
   logic [7:0] alert_w [PAMFE_N_WORDS];

   genvar i;
   generate
      for (i = 0; i < PAMFE_N_WORDS; i++) begin : g_mask
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               mask_r[i] <= MASK_RST[i];
            end else if (wr_byte && wr_slot == 5'(i)) begin
               // reserved positions store and read as zero
               mask_r[i] <= wr_byte_data & MASK_VALID[i];
            end
         end
      end
   endgenerate

   always_comb begin
      alert_w[0] = safety_alert_word_a;
      alert_w[1] = safety_alert_word_b;
      alert_w[2] = safety_alert_word_c;
      alert_w[3] = fail_alert_word_a;
      alert_w[4] = fail_alert_word_b;
      alert_w[5] = fail_alert_word_c;
      alert_w[6] = fail_alert_word_d;
   end

   // ****************************************************************
   // fail enables
   // ****************************************************************
   logic [7:0] enable_r [PAMFE_N_ENABLE];

   generate
      for (i = 0; i < PAMFE_N_ENABLE; i++) begin : g_enable
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               enable_r[i] <= ENABLE_RST[i];
            end else if (wr_byte && wr_slot == 5'(SLOT_ENABLE_BASE + 5'(i))) begin
               enable_r[i] <= wr_byte_data & ENABLE_VALID[i];
            end
         end
      end
   endgenerate

   // 1 enables a source, 0 disables it
   assign perm_fail_enable_a = enable_r[0];
   assign perm_fail_enable_b = enable_r[1];
   assign perm_fail_enable_c = enable_r[2];

   // ****************************************************************
   // aggregate evaluation
   // ****************************************************************
   logic [PAMFE_N_WORDS-1:0] hit_words;

   pamfe_alert_eval #(
      .N_WORDS  (PAMFE_N_WORDS),
      .N_SAFETY (PAMFE_N_SAFETY),
      .WORD_W   (PAMFE_WORD_W)
   ) u_eval (
      .core_clk    (core_clk),
      .rst         (rst),
      .mask_words  (mask_r),
      .alert_words (alert_w),
      .safety_agg  (masked_safety_alert_flag),
      .fail_agg    (masked_fail_alert_flag),
      .hit_words   (hit_words)
   );

   always_comb begin
      raw_alarm_flags                 = 16'h0000;
      raw_alarm_flags[RAW_SAFETY_BIT] = masked_safety_alert_flag;
      raw_alarm_flags[RAW_FAIL_BIT]   = masked_fail_alert_flag;
   end

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   logic [IRQ_W-1:0] irq_status_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_clear;
   logic [IRQ_W-1:0] irq_status_nxt;

   always_comb begin
      irq_event                 = '0;
      irq_event[IRQ_SAFETY_BIT] = masked_safety_alert_flag;
      irq_event[IRQ_FAIL_BIT]   = masked_fail_alert_flag;
      irq_clear = (wr_byte && wr_slot == SLOT_IRQ_STATUS) ?
                  wr_byte_data[IRQ_W-1:0] : '0;
      // a set in the clearing cycle wins
      irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_status_r <= IRQ_STATUS_RST;
      end else begin
         irq_status_r <= irq_status_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_mask_r <= IRQ_MASK_RST;
      end else if (wr_byte && wr_slot == SLOT_IRQ_MASK) begin
         irq_mask_r <= wr_byte_data[IRQ_W-1:0];
      end
   end

   // registered output, one cycle behind the status bits
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   logic [4:0] rd_slot;

   assign rd_slot  = reg_slot(rb.rd_addr);
   assign rb.rd_ok = (rd_slot != SLOT_NONE);

   always_comb begin
      rb.rd_data = '0;
      if (rd_slot < SLOT_ENABLE_BASE) begin
         rb.rd_data[7:0] = mask_r[3'(rd_slot)];
      end else if (rd_slot < SLOT_RAW_ALARM) begin
         rb.rd_data[7:0] = enable_r[2'(rd_slot - SLOT_ENABLE_BASE)];
      end else if (rd_slot == SLOT_RAW_ALARM) begin
         rb.rd_data[15:0] = raw_alarm_flags;
      end else if (rd_slot == SLOT_IRQ_STATUS) begin
         rb.rd_data[IRQ_W-1:0] = irq_status_r;
      end else if (rd_slot == SLOT_IRQ_MASK) begin
         rb.rd_data[IRQ_W-1:0] = irq_mask_r;
      end else if (rd_slot == SLOT_HIT_SUMMARY) begin
         rb.rd_data[PAMFE_N_WORDS-1:0] = hit_words;
      end
   end

endmodule : pamfe_top
`default_nettype wire

// ---- tb/pamfe_top_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module pamfe_top_props (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [7:0]  safety_alert_word_a,
   input wire logic [7:0]  safety_alert_word_b,
   input wire logic [7:0]  safety_alert_word_c,
   input wire logic [7:0]  fail_alert_word_a,
   input wire logic [7:0]  fail_alert_word_b,
   input wire logic [7:0]  fail_alert_word_c,
   input wire logic [7:0]  fail_alert_word_d,
   input wire logic        masked_safety_alert_flag,
   input wire logic        masked_fail_alert_flag,
   input wire logic [15:0] raw_alarm_flags,
   input wire logic [7:0]  perm_fail_enable_a,
   input wire logic [7:0]  perm_fail_enable_b,
   input wire logic [7:0]  perm_fail_enable_c,
   input wire logic        s_axi_bvalid
);
   // ************
   // aggregates and enable reset values
   // ************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // reserved positions dropped: only live bits may wake a flag
   wire logic sf_live = |{safety_alert_word_a & 8'hFC, safety_alert_word_b & 8'hF7,
                          safety_alert_word_c & 8'hF4};
   wire logic ff_live = |{fail_alert_word_a & 8'hDF, fail_alert_word_b & 8'h9F,
                          fail_alert_word_c & 8'h78, fail_alert_word_d & 8'h01};
   wire logic [55:0] words = {safety_alert_word_a, safety_alert_word_b, safety_alert_word_c,
                              fail_alert_word_a, fail_alert_word_b, fail_alert_word_c,
                              fail_alert_word_d};
   property p_raw_safety; raw_alarm_flags[12] == masked_safety_alert_flag; endproperty
   a_raw_safety: assert property (p_raw_safety) else $error("raw bit 12 off");
   property p_raw_fail; raw_alarm_flags[11] == masked_fail_alert_flag &&
      {raw_alarm_flags[15:13], raw_alarm_flags[10:0]} == 14'h0000; endproperty
   a_raw_fail: assert property (p_raw_fail) else $error("raw bit 11 off");
   property p_safety_quiet; !sf_live |=> !masked_safety_alert_flag; endproperty
   a_safety_quiet: assert property (p_safety_quiet) else $error("stray safety");
   property p_fail_quiet; !ff_live |=> !masked_fail_alert_flag; endproperty
   a_fail_quiet: assert property (p_fail_quiet) else $error("stray fail");
   // a mask write shows as bvalid, so quiet bus and words mean no flag change
   property p_safety_hold;
      !$past(rst) && $stable(words) && !s_axi_bvalid |=> $stable(masked_safety_alert_flag);
   endproperty
   a_safety_hold: assert property (p_safety_hold) else $error("safety moved");
   property p_fail_hold;
      !$past(rst) && $stable(words) && !s_axi_bvalid |=> $stable(masked_fail_alert_flag);
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("fail moved");
   property p_en_ab; $fell(rst) |-> {perm_fail_enable_a, perm_fail_enable_b} == 16'h0000;
   endproperty
   a_en_ab: assert property (p_en_ab) else $error("enable a b not zero");
   property p_en_c; $fell(rst) |-> perm_fail_enable_c == 8'h07; endproperty
   a_en_c: assert property (p_en_c) else $error("enable c default");
endmodule : pamfe_top_props
bind pamfe_top pamfe_top_props u_props (
   .core_clk(core_clk), .rst(rst), .safety_alert_word_a(safety_alert_word_a),
   .safety_alert_word_b(safety_alert_word_b), .safety_alert_word_c(safety_alert_word_c),
   .fail_alert_word_a(fail_alert_word_a), .fail_alert_word_b(fail_alert_word_b),
   .fail_alert_word_c(fail_alert_word_c), .fail_alert_word_d(fail_alert_word_d),
   .masked_safety_alert_flag(masked_safety_alert_flag), .s_axi_bvalid(s_axi_bvalid),
   .masked_fail_alert_flag(masked_fail_alert_flag), .raw_alarm_flags(raw_alarm_flags),
   .perm_fail_enable_a(perm_fail_enable_a), .perm_fail_enable_b(perm_fail_enable_b),
   .perm_fail_enable_c(perm_fail_enable_c));
`default_nettype wire

// ---- tb/pamfe_top_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module pamfe_top_bench;
   import pamfe_pkg::*;
   // ************
   // bench
   // ************
   localparam logic [7:0] RV [10] = '{8'hFC, 8'hF7, 8'hF4, 8'h5F, 8'h9F, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h07};
   localparam logic [7:0] VL [10] = '{8'hFC, 8'hF7, 8'hF4, 8'hDF, 8'h9F, 8'h78, 8'h01,
                                      8'hDF, 8'h9F, 8'hFF};
   logic        core_clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0;
   logic        awr, wrd, bv, arr, rvd, sf, ff, irq;
   logic [1:0]  br, rr, r;
   logic [7:0]  aa = 8'h00, ra = 8'h00, ena, enb, enc;
   logic [7:0]  w [7] = '{default: 8'h00};
   logic [7:0]  m [10];
   logic [15:0] raw;
   logic [31:0] wd = 32'h0000_0000, rdat, q;
   int          errors = 0, tests_run = 0;
   always #25 core_clk = ~core_clk;
   pamfe_top uut (
      .core_clk(core_clk), .rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
      .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rvd), .s_axi_rready(1'h1),
      .safety_alert_word_a(w[0]), .safety_alert_word_b(w[1]), .safety_alert_word_c(w[2]),
      .fail_alert_word_a(w[3]), .fail_alert_word_b(w[4]), .fail_alert_word_c(w[5]),
      .fail_alert_word_d(w[6]), .masked_safety_alert_flag(sf), .masked_fail_alert_flag(ff),
      .raw_alarm_flags(raw), .perm_fail_enable_a(ena), .perm_fail_enable_b(enb),
      .perm_fail_enable_c(enc), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      do begin
         @(posedge core_clk);
         if (awv && awr) awv <= 1'h0;
         if (wv && wrd) wv <= 1'h0;
      end while (bv !== 1'h1);
      r = br;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      ra <= a;
      arv <= 1'h1;
      do begin
         @(posedge core_clk);
         if (arv && arr) arv <= 1'h0;
      end while (rvd !== 1'h1);
      q = rdat;
      r = rr;
   endtask : rd
   task automatic cmp_all;
      logic s, f;
      s = |{m[0] & w[0], m[1] & w[1], m[2] & w[2]};
      f = |{m[3] & w[3], m[4] & w[4], m[5] & w[5], m[6] & w[6]};
      chk(sf, s, "safety flag");
      chk(ff, f, "fail flag");
      chk(raw, {3'h0, s, f, 11'h000}, "raw alarm");
      chk({ena, enb, enc}, {m[7], m[8], m[9]}, "enables");
   endtask : cmp_all
   task automatic print_verdict;
      if (errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      #(50 * 5000);
      errors++;
      print_verdict();
   end
   initial begin
      int          i;
      logic [31:0] d;
      void'($urandom(32'h5610));
      m = RV;
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      for (int k = 0; k < 10; k++) begin
         rd(8'(k * 4));
         chk(q, {24'h00_0000, RV[k]}, "reset value");
      end
      rd(8'h40);
      chk(q, 32'h0000_0000, "unmapped read");
      chk(r, RESP_SLVERR, "unmapped read resp");
      wr(8'h40, 32'hFFFF_FFFF);
      chk(r, RESP_SLVERR, "unmapped write");
      // bit 7 of word b is live in the default mask
      w[1] <= 8'h80;
      repeat (3) @(posedge core_clk);
      cmp_all();
      chk(irq, 1'h0, "masked irq");
      rd(OFF_HIT_SUMMARY);
      chk(q, 32'h0000_0002, "hit summary");
      rd(OFF_RAW_ALARM);
      chk(q, 32'h0000_1000, "raw alarm read");
      rd(OFF_IRQ_STATUS);
      chk(q, 32'h0000_0001, "status set");
      wr(OFF_IRQ_MASK, 32'h0000_0003);
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      chk(irq, 1'h1, "irq raised");
      // reserved bit only: status may now clear
      w[1] <= 8'h08;
      repeat (3) @(posedge core_clk);
      cmp_all();
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      rd(OFF_IRQ_STATUS);
      chk(q, 32'h0000_0000, "status cleared");
      chk(irq, 1'h0, "irq cleared");
      // sparse words so both flags toggle often
      for (int k = 0; k < 80; k++) begin
         i = $urandom_range(9);
         d = $urandom;
         wr(8'(i * 4), d);
         m[i] = d[7:0] & VL[i];
         @(posedge core_clk);
         cmp_all();
         foreach (w[j]) w[j] <= 8'($urandom & $urandom & $urandom);
         repeat (2) @(posedge core_clk);
         cmp_all();
         rd(8'(i * 4));
         chk(q, {24'h00_0000, m[i]}, "readback");
      end
      print_verdict();
   end
endmodule : pamfe_top_bench
`default_nettype wire
